// ---- pkg/efi_pkg.sv ----
package efi_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_ENABLE  = 8'h04;
  localparam logic [7:0] OFS_SIGCHG  = 8'h08;
  localparam logic [7:0] OFS_CONTROL = 8'h0C;
  localparam int unsigned ADDR_W     = 8;

  // Widths and reset values
  localparam int unsigned SIG_CH     = 30;
  localparam int unsigned NAT_W      = 5;
  localparam int unsigned EV_W       = 8;
  localparam logic [7:0]  ENABLE_RST = 8'h00;
  localparam logic [7:0]  STATUS_RST = 8'h00;

  // Status, enable bit positions
  localparam int unsigned BIT_CAS_MF = 7;
  localparam int unsigned BIT_NATBIT = 6;
  localparam int unsigned BIT_SIG    = 5;
  localparam int unsigned BIT_ALIGN  = 4;
  localparam int unsigned BIT_FLOSS  = 3;
  localparam int unsigned BIT_MIMIC  = 2;
  localparam int unsigned BIT_CRC4   = 1;
  localparam int unsigned BIT_FAS    = 0;

  // Control register fields
  localparam int unsigned CTL_CAS_EN   = 0;
  localparam int unsigned CTL_CAS_LIVE = 8;
  localparam int unsigned CTL_OOF_LIVE = 9;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // Detector outputs from the receive framer
  typedef struct packed {
    logic                cas_mframe_loss;
    logic [NAT_W-1:0]    natbit;
    logic [SIG_CH-1:0]   sig_change;
    logic                align_move_event;
    logic                frame_loss_defect;
    logic                mimic_detect_event;
    logic                crc4_err;
    logic                align_bit_err;
  } efi_det_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_WRITE,
    PH_READ1,
    PH_READ2
  } efi_phase_t;

endpackage : efi_pkg

// ---- hdl/efi_irq_ctrl.sv ----
// Behaviour
// - CAS multiframe loss declare or clear sets its status bit, interrupt if enabled.
// - Any change of national bits Sa4-Sa8 sets its status bit.
// - Any ABCD change in any of 30 channels sets signalling status bit; the code sets it only while CAS is enabled.
// - Per-channel signalling changes are held in a readable change register; the code holds them only while CAS is enabled.
// - Signalling change interrupt has no effect while CAS is turned off.
// - Apparent FAS position shift sets its status bit.
// - Out-of-frame declare or clear sets its status bit.
// - Payload mimicking framing pattern sets its status bit.
// - CRC-4 sub-multiframe mismatch sets its status bit.
// - One or more errored FAS bits set its status bit.
// - FAS bit error is reported apart from out-of-frame, never forcing it.
// - Eight enable bits are read/write, reset to 0, 1 enables a source.
// - Status flags set on event, cleared when software reads status.
//
// The address map and register access over AHB-Lite are this design's own decisions.
module efi_irq_ctrl (
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_in,
  // AHB-Lite slave
  input  wire logic              hsel_in,
  input  wire logic [31:0]       haddr_in,
  input  wire logic [1:0]        htrans_in,
  input  wire logic              hwrite_in,
  input  wire logic [2:0]        hsize_in,
  input  wire logic [31:0]       hwdata_in,
  input  wire logic              hready_in,
  output logic      [31:0]       hrdata_out,
  output logic                   hreadyout_out,
  output logic                   hresp_out,
  // Framer detectors
  input  wire efi_pkg::efi_det_t det_in,
  // Interrupt
  output logic                   irq_out
);

  // Registers
  logic [7:0]                 enable_reg;
  logic [7:0]                 status_reg;
  logic [7:0]                 status_next;
  logic [efi_pkg::SIG_CH-1:0] sigchg_reg;
  logic [efi_pkg::SIG_CH-1:0] sigchg_next;
  logic                       cas_en_reg;
  logic                       cas_prev_reg;
  logic [efi_pkg::NAT_W-1:0]  nat_prev_reg;
  logic                       oof_prev_reg;
  efi_pkg::efi_phase_t        phase_reg;
  logic [efi_pkg::ADDR_W-1:0] addr_reg;
  logic [31:0]                hrdata_reg;

  // Events
  wire logic [7:0] ev_set;
  wire logic       sig_any;
  assign sig_any = cas_en_reg && (det_in.sig_change != '0);
  assign ev_set[efi_pkg::BIT_CAS_MF] = det_in.cas_mframe_loss != cas_prev_reg;
  assign ev_set[efi_pkg::BIT_NATBIT] = det_in.natbit != nat_prev_reg;
  assign ev_set[efi_pkg::BIT_SIG]    = sig_any;
  assign ev_set[efi_pkg::BIT_ALIGN]  = det_in.align_move_event;
  assign ev_set[efi_pkg::BIT_FLOSS]  = det_in.frame_loss_defect != oof_prev_reg;
  assign ev_set[efi_pkg::BIT_MIMIC]  = det_in.mimic_detect_event;
  assign ev_set[efi_pkg::BIT_CRC4]   = det_in.crc4_err;
  assign ev_set[efi_pkg::BIT_FAS]    = det_in.align_bit_err;

  // Bus decode
  wire logic addr_take;
  wire logic wr_cycle;
  wire logic rd_cycle;
  wire logic sel_status;
  wire logic sel_enable;
  wire logic sel_sigchg;
  wire logic sel_control;
  assign addr_take   = hsel_in && hready_in && (htrans_in == efi_pkg::HTRANS_NONSEQ);
  assign wr_cycle    = phase_reg == efi_pkg::PH_WRITE;
  assign rd_cycle    = phase_reg == efi_pkg::PH_READ1;
  assign sel_status  = addr_reg == efi_pkg::OFS_STATUS;
  assign sel_enable  = addr_reg == efi_pkg::OFS_ENABLE;
  assign sel_sigchg  = addr_reg == efi_pkg::OFS_SIGCHG;
  assign sel_control = addr_reg == efi_pkg::OFS_CONTROL;

  // Read data mux
  wire logic [31:0] rd_mux;
  wire logic [31:0] ctl_view;
  assign ctl_view = (32'(cas_en_reg) << efi_pkg::CTL_CAS_EN)
                  | (32'(det_in.cas_mframe_loss) << efi_pkg::CTL_CAS_LIVE)
                  | (32'(det_in.frame_loss_defect) << efi_pkg::CTL_OOF_LIVE);
  assign rd_mux = sel_status  ? 32'(status_reg) :
                  sel_enable  ? 32'(enable_reg) :
                  sel_sigchg  ? 32'(sigchg_reg) :
                  sel_control ? ctl_view : 32'h0000_0000;

  // Clears: read-to-clear and write-one-to-clear, set wins
  wire logic [7:0]                 st_clr;
  wire logic [efi_pkg::SIG_CH-1:0] sc_clr;
  assign st_clr = (rd_cycle && sel_status) ? 8'hFF :
                  (wr_cycle && sel_status) ? hwdata_in[7:0] : 8'h00;
  assign sc_clr = (rd_cycle && sel_sigchg) ? '1 :
                  (wr_cycle && sel_sigchg) ? hwdata_in[efi_pkg::SIG_CH-1:0] : '0;
  assign status_next = (status_reg & ~st_clr) | ev_set;
  assign sigchg_next = (sigchg_reg & ~sc_clr) | (cas_en_reg ? det_in.sig_change : '0);

  // Interrupt output
  wire logic [7:0] en_eff;
  assign en_eff = enable_reg & ~(8'(!cas_en_reg) << efi_pkg::BIT_SIG);
  assign irq_out = |(status_reg & en_eff);

  // Bus outputs
  assign hreadyout_out = !rd_cycle;
  assign hresp_out     = efi_pkg::HRESP_OKAY;
  assign hrdata_out    = hrdata_reg;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= efi_pkg::PH_IDLE;
      addr_reg  <= '0;
    end else if (addr_take) begin
      phase_reg <= hwrite_in ? efi_pkg::PH_WRITE : efi_pkg::PH_READ1;
      addr_reg  <= haddr_in[efi_pkg::ADDR_W-1:0];
    end else begin
      case (phase_reg)
        efi_pkg::PH_READ1: begin
          phase_reg <= efi_pkg::PH_READ2;
        end
        default: begin
          phase_reg <= efi_pkg::PH_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_cycle) begin
      hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      enable_reg <= efi_pkg::ENABLE_RST;
      cas_en_reg <= 1'b0;
    end else if (wr_cycle) begin
      if (sel_enable) begin
        enable_reg <= hwdata_in[7:0];
      end
      if (sel_control) begin
        cas_en_reg <= hwdata_in[efi_pkg::CTL_CAS_EN];
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_reg   <= efi_pkg::STATUS_RST;
      sigchg_reg   <= '0;
      cas_prev_reg <= 1'b0;
      nat_prev_reg <= '0;
      oof_prev_reg <= 1'b0;
    end else begin
      status_reg   <= status_next;
      sigchg_reg   <= sigchg_next;
      cas_prev_reg <= det_in.cas_mframe_loss;
      nat_prev_reg <= det_in.natbit;
      oof_prev_reg <= det_in.frame_loss_defect;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  property p_cas_mf;
    $changed(det_in.cas_mframe_loss) |=> status_reg[efi_pkg::BIT_CAS_MF];
  endproperty
  a_cas_mf: assert property (p_cas_mf) else $error("CAS multiframe change not flagged");

  property p_natbit;
    $changed(det_in.natbit) |=> status_reg[efi_pkg::BIT_NATBIT];
  endproperty
  a_natbit: assert property (p_natbit) else $error("National bit change not flagged");

  property p_sig;
    (cas_en_reg && det_in.sig_change != '0) |=> status_reg[efi_pkg::BIT_SIG];
  endproperty
  a_sig: assert property (p_sig) else $error("Signalling change not flagged");

  property p_sigchg;
    cas_en_reg |=> ((sigchg_reg & $past(det_in.sig_change)) == $past(det_in.sig_change));
  endproperty
  a_sigchg: assert property (p_sigchg) else $error("Channel change bit missing");

  property p_cas_off;
    (!cas_en_reg && (status_reg & enable_reg & ~(8'h01 << efi_pkg::BIT_SIG)) == 8'h00) |-> !irq_out;
  endproperty
  a_cas_off: assert property (p_cas_off) else $error("Signalling irq while CAS off");

  property p_align;
    det_in.align_move_event |=> status_reg[efi_pkg::BIT_ALIGN];
  endproperty
  a_align: assert property (p_align) else $error("Alignment move not flagged");

  property p_floss;
    $changed(det_in.frame_loss_defect) |=> status_reg[efi_pkg::BIT_FLOSS];
  endproperty
  a_floss: assert property (p_floss) else $error("Frame loss change not flagged");

  property p_mimic;
    det_in.mimic_detect_event |=> status_reg[efi_pkg::BIT_MIMIC];
  endproperty
  a_mimic: assert property (p_mimic) else $error("Mimic not flagged");

  property p_crc4;
    det_in.crc4_err |=> status_reg[efi_pkg::BIT_CRC4];
  endproperty
  a_crc4: assert property (p_crc4) else $error("CRC-4 error not flagged");

  property p_fas;
    det_in.align_bit_err |=> status_reg[efi_pkg::BIT_FAS];
  endproperty
  a_fas: assert property (p_fas) else $error("FAS bit error not flagged");

  property p_fas_alone;
    (det_in.align_bit_err && !$changed(det_in.frame_loss_defect) && !status_reg[efi_pkg::BIT_FLOSS])
      |=> !status_reg[efi_pkg::BIT_FLOSS];
  endproperty
  a_fas_alone: assert property (p_fas_alone) else $error("FAS error raised frame loss");

  property p_enable_wr;
    (wr_cycle && sel_enable) |=> enable_reg == $past(hwdata_in[7:0]);
  endproperty
  a_enable_wr: assert property (p_enable_wr) else $error("Enable write lost");

  property p_rd_clear;
    (rd_cycle && sel_status && ev_set == 8'h00) |=>
      (status_reg == 8'h00) && (hrdata_out[7:0] == $past(status_reg));
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("Status read did not clear");

  property p_irq;
    irq_out == ((|(status_reg & enable_reg & ~(8'h01 << efi_pkg::BIT_SIG)))
                || (cas_en_reg && status_reg[efi_pkg::BIT_SIG] && enable_reg[efi_pkg::BIT_SIG]));
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised");

  property p_wait_one;
    rd_cycle |=> hreadyout_out;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("Read wait too long");

  property p_rd_wait;
    rd_cycle |-> !hreadyout_out;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("Read data phase without wait state");

  property p_rdata_hold;
    !rd_cycle |=> $stable(hrdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("Read data changed outside a read");

  property p_w1c;
    (wr_cycle && sel_status && ev_set == 8'h00)
      |=> status_reg == ($past(status_reg) & ~$past(hwdata_in[7:0]));
  endproperty
  a_w1c: assert property (p_w1c) else $error("Status write-one-to-clear failed");

  property p_sticky;
    !((rd_cycle || wr_cycle) && sel_status) |=> ((status_reg & $past(status_reg)) == $past(status_reg));
  endproperty
  a_sticky: assert property (p_sticky) else $error("Status bit dropped without a clear");

  property p_enable_hold;
    !(wr_cycle && sel_enable) |=> $stable(enable_reg);
  endproperty
  a_enable_hold: assert property (p_enable_hold) else $error("Enable changed without a write");

  property p_ctl_wr;
    (wr_cycle && sel_control) |=> cas_en_reg == $past(hwdata_in[efi_pkg::CTL_CAS_EN]);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("CAS enable write lost");

  property p_sig_off;
    (!cas_en_reg && !status_reg[efi_pkg::BIT_SIG]) |=> !status_reg[efi_pkg::BIT_SIG];
  endproperty
  a_sig_off: assert property (p_sig_off) else $error("Signalling status set while CAS off");

  property p_sigchg_off;
    (!cas_en_reg && sigchg_reg == '0) |=> sigchg_reg == '0;
  endproperty
  a_sigchg_off: assert property (p_sigchg_off) else $error("Channel change set while CAS off");

  property p_sigchg_clear;
    (rd_cycle && sel_sigchg && (!cas_en_reg || det_in.sig_change == '0))
      |=> (sigchg_reg == '0) && (hrdata_out[efi_pkg::SIG_CH-1:0] == $past(sigchg_reg));
  endproperty
  a_sigchg_clear: assert property (p_sigchg_clear) else $error("Channel change read did not clear");

  c_irq_rise: cover property ($rose(irq_out));
  c_rd_status: cover property (rd_cycle && sel_status && status_reg != 8'h00);
  c_sig_chan: cover property (cas_en_reg && det_in.sig_change != '0);
  c_set_wins: cover property (rd_cycle && sel_status && ev_set != 8'h00);
  c_cas_off_pend: cover property (!cas_en_reg && status_reg[efi_pkg::BIT_SIG]);

endmodule : efi_irq_ctrl

// ---- bench/efi_irq_ctrl_bench.sv ----
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module efi_irq_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk_in;
  logic              rst_in;
  logic              hsel_in;
  logic [31:0]       haddr_in;
  logic [1:0]        htrans_in;
  logic              hwrite_in;
  logic [2:0]        hsize_in;
  logic [31:0]       hwdata_in;
  logic              hready_in;
  logic [31:0]       hrdata_out;
  logic              hreadyout_out;
  logic              hresp_out;
  efi_pkg::efi_det_t det_in;
  logic              irq_out;
  int                errors;
  int                n_tests;

  efi_irq_ctrl u_dut (.core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .det_in(det_in), .irq_out(irq_out));
  assign hready_in = hreadyout_out;

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Bus cycles
  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk_in);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h0, ofs};
    htrans_in <= efi_pkg::HTRANS_NONSEQ;
    hwrite_in <= wr;
    @(negedge core_clk_in);
    while (hreadyout_out !== 1'b1) @(negedge core_clk_in);
    @(posedge core_clk_in);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    @(negedge core_clk_in);
    while (hreadyout_out !== 1'b1) @(negedge core_clk_in);
    q = hrdata_out;
    `CHK("hresp", efi_pkg::HRESP_OKAY, hresp_out)
    @(posedge core_clk_in);
  endtask : ahb
  task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, ofs, d, q);
  endtask : wr
  task automatic rd_chk(input logic [7:0] ofs, input logic [31:0] e);
    logic [31:0] q;
    ahb(1'b0, ofs, 32'h0, q);
    `CHK("read", e, q)
  endtask : rd_chk
  task automatic irq_chk(input logic e);
    @(negedge core_clk_in);
    `CHK("irq", e, irq_out)
  endtask : irq_chk

  // Detector stimulus: pulse fields last one cycle, levels stay
  task automatic drive(input efi_pkg::efi_det_t d);
    @(posedge core_clk_in);
    det_in <= d;
    d.sig_change = '0;
    d.align_move_event = 1'b0;
    d.mimic_detect_event = 1'b0;
    d.crc4_err = 1'b0;
    d.align_bit_err = 1'b0;
    @(posedge core_clk_in);
    det_in <= d;
  endtask : drive
  function automatic efi_pkg::efi_det_t mk(input int b);
    efi_pkg::efi_det_t d;
    d = det_in;
    d.align_bit_err = (b == 0);
    d.crc4_err = (b == 1);
    d.mimic_detect_event = (b == 2);
    d.align_move_event = (b == 4);
    return d;
  endfunction : mk

  task automatic t_regs();
    rd_chk(efi_pkg::OFS_ENABLE, 32'h0);
    rd_chk(efi_pkg::OFS_STATUS, 32'h0);
    irq_chk(1'b0);
    wr(efi_pkg::OFS_ENABLE, 32'hFF);
    rd_chk(efi_pkg::OFS_ENABLE, 32'hFF);
    wr(efi_pkg::OFS_ENABLE, 32'hA5);
    rd_chk(efi_pkg::OFS_ENABLE, 32'hA5);
    wr(8'h10, 32'hFF);
    rd_chk(8'h10, 32'h0);
  endtask : t_regs

  task automatic t_pulses();
    int bits[4] = '{0, 1, 2, 4};
    foreach (bits[i]) begin
      wr(efi_pkg::OFS_ENABLE, 32'h1 << bits[i]);
      drive(mk(bits[i]));
      irq_chk(1'b1);
      rd_chk(efi_pkg::OFS_STATUS, 32'h1 << bits[i]);
      rd_chk(efi_pkg::OFS_STATUS, 32'h0);
      irq_chk(1'b0);
    end
  endtask : t_pulses

  task automatic t_levels();
    efi_pkg::efi_det_t d;
    wr(efi_pkg::OFS_ENABLE, 32'hC8);
    for (int k = 0; k < 4; k++) begin
      d = det_in;
      d.frame_loss_defect = ~d.frame_loss_defect;
      drive(d);
      irq_chk(1'b1);
      rd_chk(efi_pkg::OFS_STATUS, 32'h08);
      rd_chk(efi_pkg::OFS_CONTROL, {22'h0, d.frame_loss_defect, d.cas_mframe_loss, 8'h0});
      d.cas_mframe_loss = ~d.cas_mframe_loss;
      drive(d);
      rd_chk(efi_pkg::OFS_STATUS, 32'h80);
      irq_chk(1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      d = det_in;
      d.natbit[i] = 1'b1;
      drive(d);
      irq_chk(1'b1);
      rd_chk(efi_pkg::OFS_STATUS, 32'h40);
    end
  endtask : t_levels

  task automatic t_mask();
    wr(efi_pkg::OFS_ENABLE, 32'h0);
    drive(mk(1));
    irq_chk(1'b0);
    wr(efi_pkg::OFS_ENABLE, 32'h02);
    irq_chk(1'b1);
    wr(efi_pkg::OFS_STATUS, 32'h02);
    irq_chk(1'b0);
    rd_chk(efi_pkg::OFS_STATUS, 32'h0);
  endtask : t_mask

  task automatic t_sig();
    efi_pkg::efi_det_t d;
    wr(efi_pkg::OFS_ENABLE, 32'h20);
    d = mk(3);
    d.sig_change = 30'h2000_0001;
    drive(d);
    irq_chk(1'b0);
    rd_chk(efi_pkg::OFS_STATUS, 32'h0);
    rd_chk(efi_pkg::OFS_SIGCHG, 32'h0);
    wr(efi_pkg::OFS_CONTROL, 32'h1);
    drive(d);
    irq_chk(1'b1);
    wr(efi_pkg::OFS_CONTROL, 32'h0);
    irq_chk(1'b0);
    wr(efi_pkg::OFS_CONTROL, 32'h1);
    irq_chk(1'b1);
    rd_chk(efi_pkg::OFS_SIGCHG, 32'h2000_0001);
    rd_chk(efi_pkg::OFS_STATUS, 32'h20);
    rd_chk(efi_pkg::OFS_SIGCHG, 32'h0);
  endtask : t_sig

  task automatic finish_test();
    if (errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  initial begin
    #200us;
    errors++;
    finish_test();
  end

  initial begin
    errors = 0;
    n_tests = 0;
    rst_in = 1'b1;
    hsel_in = 1'b0;
    haddr_in = 32'h0;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hsize_in = 3'h2;
    hwdata_in = 32'h0;
    det_in = '0;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_pulses();
    t_levels();
    t_mask();
    t_sig();
    finish_test();
  end
endmodule : efi_irq_ctrl_bench
